// ===== dv/kgd_pin_model.sv
`timescale 1ns/1ps
module kgd_pin_model (
  input  wire         clk_i,
  output logic [11:0] pin_o
);
  // scanned key up, generator inputs low
  initial pin_o = 12'h001;
  task automatic set_pins(input logic [11:0] v);
    @(posedge clk_i);
    pin_o <= v;
  endtask
endmodule // kgd_pin_model

// ===== dv/kgd_sva.sv
`timescale 1ns/1ps
module kgd_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire [11:0] pin_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        keyboard_interrupt_o,
  input wire [4:0]  generator_interrupt_out_o
);
  reg  [11:0] pin_q_ff;
  reg  [3:0]  calm_ff;
  wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        clr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 6'h14 && wb_sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // cycles for which the pins have held still
  always @(posedge clk_i) begin
    pin_q_ff <= pin_i;
    if (rst_i || pin_i != pin_q_ff) calm_ff <= 4'h0;
    else if (calm_ff != 4'hF) calm_ff <= calm_ff + 4'h1;
  end
  ////////////////////////////////////////
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_kbd_pulse; keyboard_interrupt_o |=> !keyboard_interrupt_o; endproperty
  a_kbd_pulse: assert property (p_kbd_pulse) else $error("keyboard pulse too long");
  property p_clr_drops; clr && req |=> (generator_interrupt_out_o & $past(wb_dat_i[4:0])) == 5'h00; endproperty
  a_clr_drops: assert property (p_clr_drops) else $error("flag not cleared");
  property p_hold; |($past(generator_interrupt_out_o) & ~generator_interrupt_out_o) |-> $past(clr); endproperty
  a_hold: assert property (p_hold) else $error("flag fell without clear");
  property p_wo_zero; wb_ack_o && !wb_we_i && (wb_adr_i >= 6'h20 || wb_adr_i == 6'h14) |-> wb_dat_o == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("empty read not zero");
  property p_status; wb_ack_o && !wb_we_i && wb_adr_i == 6'h18 |->
    wb_dat_o == {27'h0, $past(generator_interrupt_out_o)}; endproperty
  a_status: assert property (p_status) else $error("flag read wrong");
  property p_pins; wb_ack_o && !wb_we_i && wb_adr_i == 6'h1C && calm_ff > 4'h6 |->
    wb_dat_o == {20'h0, pin_i}; endproperty
  a_pins: assert property (p_pins) else $error("pin read wrong");
endmodule // kgd_sva

// ===== dv/kgd_tb_top.sv
`timescale 1ns/1ps
module kgd_tb_top;
  logic        clk_i;
  logic        rst_i;
  wire  [11:0] pin_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         keyboard_interrupt_o;
  wire  [4:0]  generator_interrupt_out_o;
  int          bad_count;
  int          comparisons;
  int          kbd_seen;
  logic [31:0] rd;
  logic [31:0] cfg [5] = '{32'h001, 32'h080, 32'h03F, 32'h54321, 32'h100};
  kgd_top #(.TICK_CYCLES(100)) kgd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .keyboard_interrupt_o(keyboard_interrupt_o), .generator_interrupt_out_o(generator_interrupt_out_o));
  kgd_pin_model kgd_pin_model_inst (.clk_i(clk_i), .pin_o(pin_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (keyboard_interrupt_o === 1'b1) kbd_seen <= kbd_seen + 1;
  ////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [5:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("bus ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_for(input logic kb, input string nm);
    int n;
    n = 0;
    while ((kb ? keyboard_interrupt_o : generator_interrupt_out_o[0]) !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, 32'h1, {31'h0, n < 2000});
    repeat (4) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    bad_count = 0;
    comparisons = 0;
    kbd_seen = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer(6'(4 * i), 1'b0, 32'h0);
      chk("reset value", 32'h0, rd);
    end
    xfer(6'h20, 1'b1, 32'hFFFFFFFF);
    xfer(6'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      xfer(6'(4 * i), 1'b1, cfg[i]);
      xfer(6'(4 * i), 1'b0, 32'h0);
      chk("config", cfg[i], rd);
    end
    // generators watched pin 0 before the select write; clear whatever they raised
    repeat (250) @(posedge clk_i);
    xfer(6'h14, 1'b1, 32'h1F);
    xfer(6'h18, 1'b0, 32'h0);
    chk("flags idle", 32'h0, rd);
    xfer(6'h1C, 1'b0, 32'h0);
    chk("pin state", 32'h001, rd);
    // key down on the scanned pin, generators 0 and 1 active
    kgd_pin_model_inst.set_pins(12'h006);
    wait_for(1'b1, "press interrupt");
    xfer(6'h18, 1'b0, 32'h0);
    chk("flags", 32'h3, rd);
    xfer(6'h1C, 1'b0, 32'h0);
    chk("pin state", 32'h006, rd);
    xfer(6'h14, 1'b1, 32'h3);
    chk("cleared", 32'h0, {27'h0, generator_interrupt_out_o});
    kgd_pin_model_inst.set_pins(12'h007);
    wait_for(1'b1, "release interrupt");
    chk("flags", 32'h2, {27'h0, generator_interrupt_out_o});
    chk("key events", 32'h2, 32'(kbd_seen));
    // invert generator 0 while it waits for release, then give it a falling edge
    xfer(6'h10, 1'b1, 32'h101);
    kgd_pin_model_inst.set_pins(12'h005);
    wait_for(1'b0, "inverted edge flag");
    chk("flags", 32'h3, {27'h0, generator_interrupt_out_o});
    // repeat interval 2 with release reporting: press, one repeat, release
    xfer(6'h04, 1'b1, 32'h82);
    kgd_pin_model_inst.set_pins(12'h004);
    wait_for(1'b1, "press again");
    wait_for(1'b1, "repeat interrupt");
    kgd_pin_model_inst.set_pins(12'h005);
    wait_for(1'b1, "release again");
    chk("key events", 32'h5, 32'(kbd_seen));
    conclude;
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    $display("BAD watchdog expected done seen hang");
    conclude;
  end
endmodule // kgd_tb_top
bind kgd_top kgd_sva kgd_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .keyboard_interrupt_o(keyboard_interrupt_o), .generator_interrupt_out_o(generator_interrupt_out_o));

// ===== hw/kgd_regs.vh
`ifndef KGD_REGS_VH
`define KGD_REGS_VH
// register byte offsets
`define KGD_SCAN_SEL_OFS     6'h00
`define KGD_SCAN_CTRL_OFS    6'h04
`define KGD_DEBOUNCE_OFS     6'h08
`define KGD_GEN_SEL_OFS      6'h0C
`define KGD_GEN_LEVEL_OFS    6'h10
`define KGD_GEN_CLEAR_OFS    6'h14
`define KGD_GEN_STATUS_OFS   6'h18
`define KGD_PIN_STATE_OFS    6'h1C
// scan control fields
`define KGD_SC_LEVEL_BIT     6
`define KGD_SC_REL_BIT       7
`define KGD_SC_REPEAT_LSB    0
// debounce fields
`define KGD_DB_VALUE_LSB     0
`define KGD_DB_GEN_EN_LSB    8
`define KGD_DB_SCAN_EN_BIT   13
// generator level control fields
`define KGD_GL_POL_LSB       0
`define KGD_GL_EDGE_LSB      8
// reset values
`define KGD_SCAN_SEL_RST     12'h000
`define KGD_SCAN_CTRL_RST    8'h00
`define KGD_DEBOUNCE_RST     14'h0000
`define KGD_GEN_SEL_RST      20'h00000
`define KGD_GEN_LEVEL_RST    13'h0000
// timing
`define KGD_TICK_MS          1
`define KGD_CLK_MHZ          200
`define KGD_TICK_CYCLES      (`KGD_TICK_MS * `KGD_CLK_MHZ * 1000)
`endif

// ===== hw/kgd_top.v
`timescale 1ns/1ps
// Behaviour
// - one keyboard interrupt line pulses when scanner debounce completes for press or release.
// - with active level 0 and pin enabled, a falling pin edge sets key detected.
// - key detected starts the scanner and loads debounce reload into its counter.
// - counters decrement once per 1 ms tick; interval spans 0 to 63 ms.
// - expiry with key held interrupts and reloads repeat interval; repeats while held.
// - release with release reporting on restarts debounce, interrupt when it ends.
// - scanner debounce enable 0 bypasses the scanner debounce timer.
// - repeat interval 0 disables repeated interrupts while held.
// - press level is software selectable; release reporting off when its bit is 0.
// - a pin joins scanning only when its scan enable bit is 1.
// - software reads current pin states through the pin state register.
// - five generators, each own output and source select of one of 12 pins.
// - polarity 0 makes a rising edge set key detected and load shared reload.
// - generator flag sets only if counter hits 0 while key detected still 1.
// - each generator has its own debounce enable; 0 bypasses its timer.
// - generator flag holds until software writes its clear bit.
// - edge mode after clear waits for release, idles after inactive edge.
// - inverting polarity while waiting drops key detected and returns to idle.
`include "kgd_regs.vh"
module kgd_top #(
  parameter TICK_CYCLES = `KGD_TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [11:0] pin_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire        keyboard_interrupt_o,
  output wire [4:0]  generator_interrupt_out_o
);
  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_DEB     = 2'h1;
  localparam [1:0] ST_HELD    = 2'h2;
  localparam [1:0] ST_RELDEB  = 2'h3;
  localparam [1:0] G_IDLE     = 2'h0;
  localparam [1:0] G_DEB      = 2'h1;
  localparam [1:0] G_FLAG     = 2'h2;
  localparam [1:0] G_WAIT     = 2'h3;
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [17:0] TICK_LAST = TICK_LAST_I[17:0];

  function [0:0] pin_pick;
    input [11:0] pins;
    input [3:0]  idx;
    begin
      pin_pick = (idx < 4'hC) ? pins[idx] : 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // input synchroniser and tick
  reg  [11:0] sync1_ff;
  reg  [11:0] pins_ff;
  reg  [11:0] pins_d_ff;
  reg  [17:0] tick_cnt_ff;
  reg         tick_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff    <= 12'h000;
      pins_ff     <= 12'h000;
      pins_d_ff   <= 12'h000;
      tick_cnt_ff <= 18'h00000;
      tick_ff     <= 1'b0;
    end else begin
      sync1_ff  <= pin_i;
      pins_ff   <= sync1_ff;
      pins_d_ff <= pins_ff;
      if (tick_cnt_ff == TICK_LAST) begin
        tick_cnt_ff <= 18'h00000;
        tick_ff     <= 1'b1;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 18'h00001;
        tick_ff     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  reg  [11:0] scan_pin_enable_ff;
  reg  [7:0]  scan_ctrl_ff;
  reg  [13:0] debounce_ff;
  reg  [19:0] gen_sel_ff;
  reg  [12:0] gen_level_ff;
  wire [4:0]  gen_flags;
  reg  [31:0] rdata_ff;
  reg         ack_ff;
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  wire        wb_wr1   = wb_req & wb_we_i & wb_sel_i[1];
  wire        clr_wr   = wb_wr & (wb_adr_i == `KGD_GEN_CLEAR_OFS);
  wire [4:0]  gen_clr  = clr_wr ? wb_dat_i[4:0] : 5'h00;
  wire        scan_level      = scan_ctrl_ff[`KGD_SC_LEVEL_BIT];
  wire        release_enable  = scan_ctrl_ff[`KGD_SC_REL_BIT];
  wire [5:0]  repeat_interval = scan_ctrl_ff[`KGD_SC_REPEAT_LSB +: 6];
  wire [5:0]  debounce_reload = debounce_ff[`KGD_DB_VALUE_LSB +: 6];
  wire [4:0]  gen_deb_en      = debounce_ff[`KGD_DB_GEN_EN_LSB +: 5];
  wire        scan_deb_en     = debounce_ff[`KGD_DB_SCAN_EN_BIT];
  wire [4:0]  gen_pol         = gen_level_ff[`KGD_GL_POL_LSB +: 5];
  wire [4:0]  gen_edge        = gen_level_ff[`KGD_GL_EDGE_LSB +: 5];
  always @(posedge clk_i) begin
    if (rst_i) begin
      scan_pin_enable_ff <= `KGD_SCAN_SEL_RST;
      scan_ctrl_ff       <= `KGD_SCAN_CTRL_RST;
      debounce_ff        <= `KGD_DEBOUNCE_RST;
      gen_sel_ff         <= `KGD_GEN_SEL_RST;
      gen_level_ff       <= `KGD_GEN_LEVEL_RST;
      rdata_ff           <= 32'h00000000;
      ack_ff             <= 1'b0;
    end else begin
      ack_ff <= wb_req;
      if (wb_wr | wb_wr1) begin
        case (wb_adr_i)
          `KGD_SCAN_SEL_OFS: begin
            if (wb_wr) scan_pin_enable_ff[7:0] <= wb_dat_i[7:0];
            if (wb_wr1) scan_pin_enable_ff[11:8] <= wb_dat_i[11:8];
          end
          `KGD_SCAN_CTRL_OFS: begin
            if (wb_wr) scan_ctrl_ff <= wb_dat_i[7:0];
          end
          `KGD_DEBOUNCE_OFS: begin
            if (wb_wr) debounce_ff[7:0] <= wb_dat_i[7:0];
            if (wb_wr1) debounce_ff[13:8] <= wb_dat_i[13:8];
          end
          `KGD_GEN_SEL_OFS: begin
            if (wb_wr) gen_sel_ff[7:0] <= wb_dat_i[7:0];
            if (wb_wr1) gen_sel_ff[15:8] <= wb_dat_i[15:8];
            if (wb_req & wb_we_i & wb_sel_i[2]) gen_sel_ff[19:16] <= wb_dat_i[19:16];
          end
          `KGD_GEN_LEVEL_OFS: begin
            if (wb_wr) gen_level_ff[7:0] <= wb_dat_i[7:0];
            if (wb_wr1) gen_level_ff[12:8] <= wb_dat_i[12:8];
          end
          default: begin
          end
        endcase
      end
      if (wb_req) begin
        case (wb_adr_i)
          `KGD_SCAN_SEL_OFS:   rdata_ff <= {20'h00000, scan_pin_enable_ff};
          `KGD_SCAN_CTRL_OFS:  rdata_ff <= {24'h000000, scan_ctrl_ff};
          `KGD_DEBOUNCE_OFS:   rdata_ff <= {18'h00000, debounce_ff};
          `KGD_GEN_SEL_OFS:    rdata_ff <= {12'h000, gen_sel_ff};
          `KGD_GEN_LEVEL_OFS:  rdata_ff <= {19'h00000, gen_level_ff};
          `KGD_GEN_STATUS_OFS: rdata_ff <= {27'h0000000, gen_flags};
          `KGD_PIN_STATE_OFS:  rdata_ff <= {20'h00000, pins_ff};
          default:             rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;

  ////////////////////////////////////////////////////////////////
  // keyboard scanner
  wire [11:0] act_now  = scan_level ? pins_ff : ~pins_ff;
  wire [11:0] act_prev = scan_level ? pins_d_ff : ~pins_d_ff;
  wire        scan_edge = |(act_now & ~act_prev & scan_pin_enable_ff);
  wire        scan_held = |(act_now & scan_pin_enable_ff);
  reg  [1:0]  kst_ff;
  reg  [5:0]  kcnt_ff;
  reg         key_hit_ff;
  reg         kirq_ff;
  wire        kexp = ~scan_deb_en | (kcnt_ff == 6'h00);
  always @(posedge clk_i) begin
    if (rst_i) begin
      kst_ff     <= ST_IDLE;
      kcnt_ff    <= 6'h00;
      key_hit_ff <= 1'b0;
      kirq_ff    <= 1'b0;
    end else begin
      kirq_ff <= 1'b0;
      if (scan_edge) key_hit_ff <= 1'b1;
      else if (~scan_held) key_hit_ff <= 1'b0;
      case (kst_ff)
        ST_IDLE: begin
          if (key_hit_ff) begin
            kst_ff  <= ST_DEB;
            kcnt_ff <= debounce_reload;
          end
        end
        ST_DEB: begin
          if (~key_hit_ff) begin
            kst_ff <= ST_IDLE;
          end else if (tick_ff) begin
            if (kexp) begin
              kirq_ff <= 1'b1;
              kst_ff  <= ST_HELD;
              kcnt_ff <= repeat_interval;
            end else begin
              kcnt_ff <= kcnt_ff - 6'h01;
            end
          end
        end
        ST_HELD: begin
          if (~key_hit_ff) begin
            if (release_enable) begin
              kst_ff  <= ST_RELDEB;
              kcnt_ff <= debounce_reload;
            end else begin
              kst_ff <= ST_IDLE;
            end
          end else if (tick_ff && repeat_interval != 6'h00) begin
            if (kcnt_ff == 6'h00) begin
              kirq_ff <= 1'b1;
              kcnt_ff <= repeat_interval;
            end else begin
              kcnt_ff <= kcnt_ff - 6'h01;
            end
          end
        end
        ST_RELDEB: begin
          if (tick_ff) begin
            if (kexp) begin
              kirq_ff <= 1'b1;
              kst_ff  <= ST_IDLE;
            end else begin
              kcnt_ff <= kcnt_ff - 6'h01;
            end
          end
        end
        default: kst_ff <= ST_IDLE;
      endcase
    end
  end
  assign keyboard_interrupt_o = kirq_ff;

  ////////////////////////////////////////////////////////////////
  // gpio interrupt generators
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : gen_irq
      wire       lvl_now  = pin_pick(pins_ff, gen_sel_ff[4*g +: 4]) ^ gen_pol[g];
      wire       lvl_prev = pin_pick(pins_d_ff, gen_sel_ff[4*g +: 4]) ^ gen_pol[g];
      reg  [1:0] gst_ff;
      reg  [5:0] gcnt_ff;
      reg        flag_ff;
      assign gen_flags[g] = flag_ff;
      wire       gexp = ~gen_deb_en[g] | (gcnt_ff == 6'h00);
      always @(posedge clk_i) begin
        if (rst_i) begin
          gst_ff         <= G_IDLE;
          gcnt_ff        <= 6'h00;
          flag_ff        <= 1'b0;
        end else begin
          case (gst_ff)
            G_IDLE: begin
              if (lvl_now & (~lvl_prev | ~gen_edge[g])) begin
                gst_ff  <= G_DEB;
                gcnt_ff <= debounce_reload;
              end
            end
            G_DEB: begin
              if (~lvl_now) begin
                gst_ff <= G_IDLE;
              end else if (tick_ff) begin
                if (gexp) begin
                  flag_ff        <= 1'b1;
                  gst_ff         <= G_FLAG;
                end else begin
                  gcnt_ff <= gcnt_ff - 6'h01;
                end
              end
            end
            G_FLAG: begin
              if (gen_clr[g]) begin
                flag_ff <= 1'b0;
                gst_ff <= gen_edge[g] ? G_WAIT : G_IDLE;
              end
            end
            G_WAIT: begin
              if (~lvl_now) gst_ff <= G_IDLE;
            end
            default: gst_ff <= G_IDLE;
          endcase
        end
      end
    end
  endgenerate
  assign generator_interrupt_out_o = gen_flags;
endmodule // kgd_top
